// File: far_side_model.sv
// Reset sources and a sped-up RC clock for the reset sequencer.
// Assumes src_q bit n, for n 1..7, drives the source whose flag sits at bit n.
`timescale 1ns/10ps
module far_side_model (
    input  wire logic  hclk,
    input  wire logic  global_reset_n,
    output logic       low_speed_rc_clock,
    output logic [7:0] src_q
);
    initial
    begin
        low_speed_rc_clock = 1'h0;
        src_q = 8'h80;
        repeat (40) @(posedge hclk);
        src_q[7] <= 1'h0;
    end
    always #20 low_speed_rc_clock = ~low_speed_rc_clock;
    always @(posedge hclk)
        if (!global_reset_n)
            src_q[6] <= 1'h0;
    task automatic pulse(input int idx, input int len);
        src_q[idx] <= 1'h1;
        repeat (len) @(posedge hclk);
        src_q[idx] <= 1'h0;
    endtask : pulse
endmodule : far_side_model

// File: global_reset_sequencer.sv
// Global reset sequencer: merges eight reset sources, stretches the reset,
// records causes in flags reachable over AHB-Lite.
// Assumes hresetn is the raw supply-on reset; RC clock arrives as a plain input.
// Function
// - Any of eight sources asserts the single chip-wide global reset.
// - After supply-on release, global reset holds 5 ms more.
// - Supply-drop asserts reset; release 5 ms after its output returns high.
// - Watchdog overflow reset holds global reset 5 ms.
// - Core software reset request holds global reset 5 ms.
// - Core lockup holds global reset 5 ms.
// - Reset pin low is filtered for 4 RC clock cycles first.
// - Pin low holds reset; 5 ms more after pin goes high.
// - PC range overflow seen in one clock, resets 5 ms, then clears.
// - Programming enable high holds reset; 5 ms more after it drops.
// - After normal operation begins, programming mode entry is refused.
// - Flag bits 7..2: prog, pc range, pin, lockup, soft, watchdog.
// - Flags stay set until software writes 0; hardware never clears.
// - After supply-on reset the flag register reads 0x00000001.
// - Bit 1 records supply drop, bit 0 supply on; write 0 clears.
`timescale 1ns/10ps
module global_reset_sequencer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        low_speed_rc_clock,
    input  wire logic        supply_drop_reset_n,
    input  wire logic        watchdog_overflow_reset,
    input  wire logic        core_reset_request,
    input  wire logic        core_lockup,
    input  wire logic        reset_pin_n,
    input  wire logic        pc_out_of_range,
    input  wire logic        prog_enable,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             global_reset_n,
    output logic             irq
);
    typedef struct packed {
        rst_seq_pkg::seq_state_e state;
        logic [7:0]              ext_cnt;
        logic                    rc_prev;
        logic                    hold_prev;
        logic                    run_seen;
        logic [7:0]              cause;
        logic [31:0]             supply_cfg;
        logic [7:0]              irq_stat;
        logic [7:0]              irq_mask;
        rst_seq_pkg::ahb_req_s   req;
        logic [31:0]             rdata;
        logic                    grst_n;
        logic                    irq;
    } state_s;

    state_s q, d;
    logic   rc_tick;
    logic   pin_low_filt;
    logic   prog_ok;
    logic   hold_now;
    logic   any_event;
    logic [7:0] events;

    assign rc_tick = low_speed_rc_clock && !q.rc_prev;

    lsrc_edge_filter #(
        .TICKS (rst_seq_pkg::PIN_FILTER_TICKS)
    ) u_pin_filter (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .tick      (rc_tick),
        .level_low (!reset_pin_n),
        .filtered  (pin_low_filt)
    );

    assign prog_ok = prog_enable && !q.run_seen;

    always_comb
    begin
        events = 8'h00;
        events[rst_seq_pkg::FLAG_SUPPLY_DROP] = !supply_drop_reset_n;
        events[rst_seq_pkg::FLAG_WATCHDOG]    = watchdog_overflow_reset;
        events[rst_seq_pkg::FLAG_SOFT]        = core_reset_request;
        events[rst_seq_pkg::FLAG_LOCKUP]      = core_lockup;
        events[rst_seq_pkg::FLAG_PIN]         = pin_low_filt;
        events[rst_seq_pkg::FLAG_PC_RANGE]    = pc_out_of_range;
        events[rst_seq_pkg::FLAG_PROG]        = prog_ok;
    end

    assign any_event = |events;
    assign hold_now  = any_event;

    always_comb
    begin
        logic       wr_hit;
        logic [7:0] wbyte;
        wr_hit = 1'b0;
        wbyte  = 8'h00;
        d = q;
        d.rc_prev   = low_speed_rc_clock;
        d.hold_prev = hold_now;

        // Sequencer
        case (q.state)
            rst_seq_pkg::ST_RESET:
            begin
                d.grst_n = 1'b0;
                if (!hold_now)
                begin
                    d.state   = rst_seq_pkg::ST_EXTEND;
                    d.ext_cnt = 8'h00;
                end
            end
            rst_seq_pkg::ST_EXTEND:
            begin
                d.grst_n = 1'b0;
                if (hold_now)
                    d.state = rst_seq_pkg::ST_RESET;
                else if (rc_tick)
                begin
                    if (q.ext_cnt == 8'(rst_seq_pkg::EXTEND_TICKS - 1))
                    begin
                        d.state    = rst_seq_pkg::ST_RUN;
                        d.grst_n   = 1'b1;
                        d.run_seen = 1'b1;
                    end
                    else
                        d.ext_cnt = q.ext_cnt + 8'h01;
                end
            end
            rst_seq_pkg::ST_RUN:
            begin
                if (hold_now)
                begin
                    d.state  = rst_seq_pkg::ST_RESET;
                    d.grst_n = 1'b0;
                end
            end
            default:
            begin
                d.state  = rst_seq_pkg::ST_RESET;
                d.grst_n = 1'b0;
            end
        endcase

        // AHB data phase
        if (q.req.valid && q.req.write)
        begin
            wr_hit = 1'b1;
            wbyte  = hwdata[7:0];
            case (q.req.addr)
                rst_seq_pkg::CAUSE_OFFSET:
                    d.cause = q.cause & wbyte;
                rst_seq_pkg::SUPPLY_CFG_OFFSET:
                    d.supply_cfg = hwdata & rst_seq_pkg::SUPPLY_CFG_MASK;
                rst_seq_pkg::IRQ_STATUS_OFFSET:
                    d.irq_stat = q.irq_stat & ~wbyte;
                rst_seq_pkg::IRQ_MASK_OFFSET:
                    d.irq_mask = wbyte;
                default:
                    wr_hit = 1'b0;
            endcase
        end

        d.cause    = d.cause | events;
        d.irq_stat = d.irq_stat | (events & ~{8{q.hold_prev}});
        d.irq      = |(d.irq_stat & d.irq_mask);

        // Address phase
        d.req.valid = hsel && hready && htrans[1];
        d.req.write = hwrite;
        d.req.addr  = haddr[7:0];
        d.rdata     = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            case (haddr[7:0])
                rst_seq_pkg::CAUSE_OFFSET:      d.rdata = {24'h000000, q.cause};
                rst_seq_pkg::SUPPLY_CFG_OFFSET: d.rdata = q.supply_cfg;
                rst_seq_pkg::IRQ_STATUS_OFFSET: d.rdata = {24'h000000, q.irq_stat};
                rst_seq_pkg::IRQ_MASK_OFFSET:   d.rdata = {24'h000000, q.irq_mask};
                default:                        d.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_hit && hsize == 3'h7)
            d.irq = q.irq;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q            <= '0;
            q.state      <= rst_seq_pkg::ST_RESET;
            q.cause      <= rst_seq_pkg::CAUSE_RESET;
            q.supply_cfg <= rst_seq_pkg::SUPPLY_CFG_RESET;
        end
        else
            q <= d;
    end

    assign hrdata         = q.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign global_reset_n = q.grst_n;
    assign irq            = q.irq;

endmodule : global_reset_sequencer

// File: global_reset_sequencer_test.sv
// Self-checking bench for the global reset sequencer.
// Assumes far_side_model drives the RC clock and all sources except supply-on, which is hresetn from this bench.
`timescale 1ns/10ps
module global_reset_sequencer_test;
    logic        hclk = 1'h0;
    logic        hresetn = 1'h0;
    logic        hsel = 1'h0;
    logic        hwrite = 1'h0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout, global_reset_n, irq, rc;
    logic [7:0]  src;
    int          err_total = 0;
    int          check_count = 0;
    far_side_model far (.hclk(hclk), .global_reset_n(global_reset_n),
        .low_speed_rc_clock(rc), .src_q(src));
    global_reset_sequencer uut (.hclk(hclk), .hresetn(hresetn),
        .low_speed_rc_clock(rc), .supply_drop_reset_n(!src[1]),
        .watchdog_overflow_reset(src[2]), .core_reset_request(src[3]),
        .core_lockup(src[4]), .reset_pin_n(!src[5]), .pc_out_of_range(src[6]),
        .prog_enable(src[7]), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .global_reset_n(global_reset_n), .irq(irq));
    initial forever #5 hclk = ~hclk;
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n = 0;
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 99);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 99);
        rd = hrdata;
        chk("bus wait", 32'h1, n < 99);
        if (n >= 99)
            give_verdict();
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'h1, a, d, v);
        repeat (2) @(posedge hclk);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        bus(1'h0, a, 32'h0, v);
        chk(nm, e, v);
    endtask : rdc
    task automatic wait_gr(output int n);
        for (n = 0; global_reset_n !== 1'h1 && n < 3000; n++)
            @(posedge hclk);
        chk("release wait", 32'h1, n < 3000);
        if (n >= 3000)
            give_verdict();
    endtask : wait_gr
    task automatic t_boot;
        int n;
        wait_gr(n);
        rdc("flags", 8'h08, 32'h81);
        rdc("cfg", 8'h14, rst_seq_pkg::SUPPLY_CFG_RESET);
        rdc("unmapped", 8'h30, 32'h0);
        wr(8'h08, 32'h0);
        rdc("cleared", 8'h08, 32'h0);
        $display("boot test done");
    endtask : t_boot
    task automatic t_sources;
        int n;
        for (int i = 1; i < 7; i++)
        begin
            far.pulse(i, 40);
            chk("held", 32'h0, global_reset_n);
            wait_gr(n);
            chk("stretch", 32'h1, n > 560 && n < 700);
            rdc("cause", 8'h08, 32'h1 << i);
            wr(8'h08, 32'h0);
            if (i == 1)
                chk("masked", 32'h0, irq);
            wr(8'h24, 32'hFF);
            chk("irq", 32'h1, irq);
            wr(8'h20, 32'hFF);
            chk("irq clear", 32'h0, irq);
        end
        $display("source test done");
    endtask : t_sources
    task automatic t_overlap;
        int n;
        fork
            far.pulse(2, 40);
            far.pulse(4, 200);
        join
        wait_gr(n);
        chk("restart", 32'h1, n > 560 && n < 700);
        rdc("both", 8'h08, 32'h14);
        wr(8'h08, 32'h0);
        $display("overlap test done");
    endtask : t_overlap
    task automatic t_prog;
        far.pulse(7, 40);
        chk("no prog", 32'h1, global_reset_n);
        rdc("no flag", 8'h08, 32'h0);
        $display("prog test done");
    endtask : t_prog
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        t_boot();
        t_sources();
        t_overlap();
        t_prog();
        give_verdict();
    end
endmodule : global_reset_sequencer_test

// File: lsrc_edge_filter.sv
// Low-level filter for one input, counted on RC ticks that arrive on the tick input.
// Assumes the input and the RC clock level are synchronous to hclk.
`timescale 1ns/10ps
module lsrc_edge_filter #(
    parameter int TICKS = 4
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic tick,
    input  wire logic level_low,
    output logic      filtered
);
    typedef struct packed {
        logic [2:0] cnt;
        logic       out;
    } flt_s;

    flt_s q, d;

    always_comb
    begin
        d = q;
        if (!level_low)
        begin
            d.cnt = 3'h0;
            d.out = 1'b0;
        end
        else if (tick && !q.out)
        begin
            if (q.cnt == 3'(TICKS - 1))
                d.out = 1'b1;
            else
                d.cnt = q.cnt + 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            q <= '0;
        else
            q <= d;
    end

    assign filtered = q.out;

endmodule : lsrc_edge_filter

// File: rst_seq_assertions.sv
// Port checker for the reset sequencer, bound to its top module.
// Assumes the RC clock ticks every 4 hclk cycles, as the bench makes it.
`timescale 1ns/10ps
module rst_seq_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic supply_drop_reset_n,
    input wire logic watchdog_overflow_reset,
    input wire logic core_reset_request,
    input wire logic core_lockup,
    input wire logic reset_pin_n,
    input wire logic pc_out_of_range,
    input wire logic prog_enable,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic global_reset_n
);
    logic       src;
    logic [9:0] quiet_q;
    logic [9:0] quiet_d;
    assign src = watchdog_overflow_reset | core_reset_request | core_lockup
                 | pc_out_of_range | !supply_drop_reset_n;
    // Cycles since any source was last active
    always_comb
    begin
        quiet_d = quiet_q + {9'h0, quiet_q != 10'h3FF};
        if (src || !reset_pin_n || prog_enable)
            quiet_d = 10'h0;
    end
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            quiet_q <= 10'h0;
        else
            quiet_q <= quiet_d;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    soft_req_a: assert property ($rose(core_reset_request) && global_reset_n
        |-> ##[1:2] !global_reset_n) else $error("soft request missed");
    wdog_a: assert property ($rose(watchdog_overflow_reset) && global_reset_n
        |-> ##[1:2] !global_reset_n) else $error("watchdog missed");
    drop_a: assert property ($fell(supply_drop_reset_n) && global_reset_n
        |-> ##[1:2] !global_reset_n) else $error("supply drop missed");
    hold_src_a: assert property (src && !global_reset_n |=> !global_reset_n)
        else $error("reset released under source");
    pin_filter_a: assert property ($fell(reset_pin_n) && global_reset_n && !src
        |=> global_reset_n [*8]) else $error("pin not filtered");
    stay_run_a: assert property (global_reset_n && !src && reset_pin_n
        |=> global_reset_n) else $error("reset without source");
    extend_a: assert property ($rose(global_reset_n) |-> quiet_q >= 10'h258)
        else $error("extension too short");
    cover property ($fell(global_reset_n));
    cover property ($rose(global_reset_n));
    cover property (prog_enable && global_reset_n);
endmodule : rst_seq_assertions

bind global_reset_sequencer rst_seq_assertions chk_i (.hclk(hclk), .hresetn(hresetn),
    .supply_drop_reset_n(supply_drop_reset_n), .core_lockup(core_lockup),
    .watchdog_overflow_reset(watchdog_overflow_reset), .reset_pin_n(reset_pin_n),
    .core_reset_request(core_reset_request), .pc_out_of_range(pc_out_of_range),
    .prog_enable(prog_enable), .hreadyout(hreadyout), .hresp(hresp),
    .global_reset_n(global_reset_n));

// File: rst_seq_pkg.sv
// Package for the global reset sequencer: register map, flag layout, timing.
// Assumes a 100 MHz bus clock and a 32 kHz low-speed RC clock sampled as an input.
package rst_seq_pkg;

    // Register byte offsets
    localparam logic [7:0]  CAUSE_OFFSET     = 8'h08;
    localparam logic [7:0]  SUPPLY_CFG_OFFSET = 8'h14;
    localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'h20;
    localparam logic [7:0]  IRQ_MASK_OFFSET  = 8'h24;

    // Reset cause flag positions
    localparam int FLAG_SUPPLY_ON  = 0;
    localparam int FLAG_SUPPLY_DROP = 1;
    localparam int FLAG_WATCHDOG   = 2;
    localparam int FLAG_SOFT       = 3;
    localparam int FLAG_LOCKUP     = 4;
    localparam int FLAG_PIN        = 5;
    localparam int FLAG_PC_RANGE   = 6;
    localparam int FLAG_PROG       = 7;
    localparam int NUM_SOURCES     = 8;

    // Reset values and supply config write mask
    localparam logic [7:0]  CAUSE_RESET      = 8'h01;
    localparam logic [31:0] SUPPLY_CFG_RESET = 32'h0000_0002;
    localparam logic [31:0] SUPPLY_CFG_MASK  = 32'h0000_001E;

    // Timing: 5 ms extension counted on the 32 kHz clock
    localparam int EXTEND_US       = 5000;
    localparam int LSRC_HZ         = 32000;
    localparam int EXTEND_TICKS    = (EXTEND_US * LSRC_HZ) / 1000000;
    localparam int PIN_FILTER_TICKS = 4;

    typedef enum logic [1:0] {
        ST_RESET  = 2'b00,
        ST_EXTEND = 2'b01,
        ST_RUN    = 2'b11
    } seq_state_e;

    // AHB request as captured in the address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_req_s;

endpackage : rst_seq_pkg
